/* File: hdl/flash_host_ctrl.sv */
// host sequencer driving boot-block flash pins for erase, suspend, resume, program and reads
`default_nettype none
module flash_host_ctrl #(
  parameter int         ACCESS_CYC = 4,
  parameter logic       BOOT_TOP   = 1'b0
) (
  // clock and reset
  input  wire logic        i_ref_clk,
  input  wire logic        i_rst,
  // user command port
  input  wire logic        i_cmd_valid,
  input  wire logic [2:0]  i_cmd_op,
  input  wire logic [16:0] i_cmd_addr,
  input  wire logic [7:0]  i_cmd_data,
  input  wire logic        i_boot_via_oe,
  output logic             o_cmd_ready,
  output logic             o_done,
  output logic             o_err,
  output logic [7:0]       o_rd_data,
  output logic             o_erase_active,
  output logic             o_suspended,
  // flash pins
  output logic [16:0]      o_flash_addr,
  output logic [7:0]       o_flash_dq_out,
  output logic             o_flash_dq_oe,
  input  wire logic [7:0]  i_flash_dq_in,
  output logic             o_flash_ce_n,
  output logic             o_flash_oe_n,
  output logic             o_flash_we_n,
  output logic             o_flash_pd_n,
  output logic             o_flash_pd_hv,
  output logic             o_flash_oe_hv,
  output logic             o_flash_vpp_en
);
  localparam int TW = flash_host_pkg::TIMER_W;

  flash_host_pkg::state_t st_q, st_d;
  flash_host_pkg::op_t    op_q, op_d;
  logic [16:0] addr_q, addr_d;
  logic [7:0]  cmd0_q, cmd0_d, cmd1_q, cmd1_d;
  logic        two_q, two_d, idx_q, idx_d;
  logic        poll_q, poll_d, rd_q, rd_d, unl_q, unl_d, via_oe_q, via_oe_d;
  logic        ers_q, ers_d, susp_q, susp_d, ers_boot_q, ers_boot_d;
  logic [1:0]  blk_q, blk_d;
  logic        ce_n_q, ce_n_d, oe_n_q, oe_n_d, we_n_q, we_n_d;
  logic        pd_n_q, pd_n_d, pd_hv_q, pd_hv_d, oe_hv_q, oe_hv_d, vpp_q, vpp_d;
  logic [7:0]  dq_q, dq_d, rdat_q, rdat_d;
  logic        dq_oe_q, dq_oe_d, done_q, done_d, err_q, err_d;
  logic        tmr_load, tmr_done;
  logic [TW-1:0] tmr_val;
  logic [1:0]  cblk;

  cycle_timer #(.W(TW)) u_timer (
    .i_ref_clk (i_ref_clk),
    .i_rst     (i_rst),
    .i_load    (tmr_load),
    .i_count   (tmr_val),
    .o_done    (tmr_done)
  );

  // ***********************************************
  // sequencer
  // ***********************************************
  always_comb begin
    st_d = st_q; op_d = op_q; addr_d = addr_q; cmd0_d = cmd0_q; cmd1_d = cmd1_q;
    two_d = two_q; idx_d = idx_q; poll_d = poll_q; rd_d = rd_q; unl_d = unl_q; via_oe_d = via_oe_q;
    ers_d = ers_q; susp_d = susp_q; ers_boot_d = ers_boot_q; blk_d = blk_q;
    ce_n_d = ce_n_q; oe_n_d = oe_n_q; we_n_d = we_n_q; pd_n_d = pd_n_q; pd_hv_d = pd_hv_q;
    oe_hv_d = oe_hv_q; vpp_d = vpp_q; dq_d = dq_q; rdat_d = rdat_q; dq_oe_d = dq_oe_q;
    done_d = 1'b0; err_d = 1'b0; tmr_load = 1'b0; tmr_val = '0;
    cblk = flash_host_pkg::block_of(i_cmd_addr, BOOT_TOP);
    case (st_q)
      flash_host_pkg::ST_BOOT: begin
        pd_n_d = 1'b1;
        if (!pd_n_q) begin
          tmr_load = 1'b1;
          tmr_val  = TW'(flash_host_pkg::PD_RECOVERY_CYC);
        end else if (tmr_done) begin
          st_d = flash_host_pkg::ST_IDLE;
        end
      end
      flash_host_pkg::ST_IDLE: begin
        if (i_cmd_valid) begin
          op_d = flash_host_pkg::op_t'(i_cmd_op); addr_d = i_cmd_addr; idx_d = 1'b0;
          two_d = 1'b1; poll_d = 1'b0; rd_d = 1'b0; unl_d = 1'b0; via_oe_d = i_boot_via_oe;
          st_d = flash_host_pkg::ST_PREP;
          case (i_cmd_op)
            flash_host_pkg::OP_ERASE: begin
              cmd0_d = flash_host_pkg::CMD_ERASE_SETUP;
              cmd1_d = flash_host_pkg::CMD_CONFIRM;
              unl_d = (cblk == flash_host_pkg::BLK_BOOT);
              if (ers_q) begin
                err_d = 1'b1;
                st_d = flash_host_pkg::ST_IDLE;
              end
            end
            flash_host_pkg::OP_PROGRAM: begin
              cmd0_d = flash_host_pkg::CMD_PROG_SETUP; cmd1_d = i_cmd_data; poll_d = 1'b1;
              unl_d = (cblk == flash_host_pkg::BLK_BOOT);
              if ((ers_q && !susp_q) || (susp_q && cblk == blk_q)) begin
                err_d = 1'b1;
                st_d = flash_host_pkg::ST_IDLE;
              end
            end
            flash_host_pkg::OP_SUSPEND: begin
              cmd0_d = flash_host_pkg::CMD_SUSPEND; two_d = 1'b0; poll_d = 1'b1;
              if (!ers_q || susp_q) begin
                err_d = 1'b1;
                st_d = flash_host_pkg::ST_IDLE;
              end
            end
            flash_host_pkg::OP_RESUME: begin
              cmd0_d = flash_host_pkg::CMD_READ_STATUS; cmd1_d = flash_host_pkg::CMD_CONFIRM;
              unl_d = ers_boot_q;
              if (!susp_q) begin
                err_d = 1'b1;
                st_d = flash_host_pkg::ST_IDLE;
              end
            end
            flash_host_pkg::OP_READ: begin
              cmd0_d = flash_host_pkg::CMD_READ_ARRAY; two_d = 1'b0; rd_d = 1'b1;
              if (ers_q && !susp_q || susp_q && cblk == blk_q) begin
                err_d = 1'b1;
                st_d = flash_host_pkg::ST_IDLE;
              end
            end
            flash_host_pkg::OP_STATUS: begin
              cmd0_d = flash_host_pkg::CMD_READ_STATUS; two_d = 1'b0; rd_d = 1'b1;
            end
            default: begin
              err_d = 1'b1;
              st_d = flash_host_pkg::ST_IDLE;
            end
          endcase
        end
      end
      flash_host_pkg::ST_PREP: begin
        tmr_load = 1'b1;
        tmr_val  = unl_q ? TW'(flash_host_pkg::HV_SETUP_CYC) : TW'(flash_host_pkg::VPP_SETUP_CYC);
        if (op_q == flash_host_pkg::OP_ERASE || op_q == flash_host_pkg::OP_PROGRAM) begin
          vpp_d = 1'b1;
        end
        if (unl_q && !via_oe_q) begin
          pd_hv_d = 1'b1;
        end
        if (unl_q && via_oe_q) begin
          oe_hv_d = 1'b1;
        end
        st_d = flash_host_pkg::ST_W_WE;
      end
      flash_host_pkg::ST_W_WE: begin
        if (tmr_done) begin
          we_n_d = 1'b0; dq_oe_d = 1'b1;
          dq_d = idx_q ? cmd1_q : cmd0_q;
          st_d = flash_host_pkg::ST_W_CE;
        end
      end
      flash_host_pkg::ST_W_CE: begin
        ce_n_d = 1'b0;
        st_d = flash_host_pkg::ST_W_REL;
      end
      flash_host_pkg::ST_W_REL: begin
        ce_n_d = 1'b1; // latch edge while write enable stays low
        st_d = flash_host_pkg::ST_W_END;
      end
      flash_host_pkg::ST_W_END: begin
        we_n_d = 1'b1; dq_oe_d = 1'b0;
        if (two_q && !idx_q) begin
          idx_d = 1'b1;
          st_d = flash_host_pkg::ST_W_WE;
        end else begin
          tmr_load = 1'b1;
          tmr_val  = TW'(flash_host_pkg::HV_HOLD_CYC);
          st_d = flash_host_pkg::ST_HOLD;
          if (op_q == flash_host_pkg::OP_ERASE) begin
            ers_d = 1'b1; ers_boot_d = unl_q; blk_d = flash_host_pkg::block_of(addr_q, BOOT_TOP);
          end
          if (op_q == flash_host_pkg::OP_RESUME) begin
            susp_d = 1'b0;
          end
        end
      end
      flash_host_pkg::ST_HOLD: begin
        if (tmr_done || !oe_hv_q) begin
          oe_hv_d = 1'b0;
          st_d = (poll_q || rd_q) ? flash_host_pkg::ST_R_EN : flash_host_pkg::ST_FIN;
        end
      end
      flash_host_pkg::ST_R_EN: begin
        ce_n_d = 1'b0; oe_n_d = 1'b0;
        if (ce_n_q) begin
          tmr_load = 1'b1;
          tmr_val  = TW'(ACCESS_CYC);
        end else if (tmr_done) begin
          st_d = flash_host_pkg::ST_R_SMP;
        end
      end
      flash_host_pkg::ST_R_SMP: begin
        rdat_d = i_flash_dq_in; ce_n_d = 1'b1; oe_n_d = 1'b1;
        st_d = flash_host_pkg::ST_R_GAP;
      end
      flash_host_pkg::ST_R_GAP: begin
        if (poll_q && !rdat_q[flash_host_pkg::SR_READY_BIT]) begin
          st_d = flash_host_pkg::ST_R_EN;
        end else begin
          st_d = flash_host_pkg::ST_FIN;
        end
      end
      flash_host_pkg::ST_FIN: begin
        done_d = 1'b1;
        st_d = flash_host_pkg::ST_IDLE;
        if (op_q == flash_host_pkg::OP_SUSPEND) begin
          susp_d = rdat_q[flash_host_pkg::SR_SUSP_BIT];
          ers_d  = rdat_q[flash_host_pkg::SR_SUSP_BIT];
        end
        if (op_q == flash_host_pkg::OP_STATUS && rdat_q[flash_host_pkg::SR_READY_BIT] &&
            !rdat_q[flash_host_pkg::SR_SUSP_BIT]) begin
          ers_d = 1'b0;
        end
        if (op_q == flash_host_pkg::OP_PROGRAM || !ers_d) begin
          vpp_d = ers_d;
          pd_hv_d = ers_d && ers_boot_q && !via_oe_q;
        end
      end
      default: begin
        st_d = flash_host_pkg::ST_BOOT;
      end
    endcase
  end

  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      st_q <= flash_host_pkg::ST_BOOT; op_q <= flash_host_pkg::OP_STATUS; addr_q <= '0;
      cmd0_q <= 8'h00; cmd1_q <= 8'h00; two_q <= 1'b0; idx_q <= 1'b0; poll_q <= 1'b0;
      rd_q <= 1'b0; unl_q <= 1'b0; via_oe_q <= 1'b0; ers_q <= 1'b0; susp_q <= 1'b0;
      ers_boot_q <= 1'b0; blk_q <= 2'h0; ce_n_q <= 1'b1; oe_n_q <= 1'b1; we_n_q <= 1'b1;
      pd_n_q <= 1'b0; pd_hv_q <= 1'b0; oe_hv_q <= 1'b0; vpp_q <= 1'b0; dq_q <= 8'h00;
      rdat_q <= 8'h00; dq_oe_q <= 1'b0; done_q <= 1'b0; err_q <= 1'b0;
    end else begin
      st_q <= st_d; op_q <= op_d; addr_q <= addr_d; cmd0_q <= cmd0_d; cmd1_q <= cmd1_d;
      two_q <= two_d; idx_q <= idx_d; poll_q <= poll_d; rd_q <= rd_d; unl_q <= unl_d;
      via_oe_q <= via_oe_d; ers_q <= ers_d; susp_q <= susp_d; ers_boot_q <= ers_boot_d;
      blk_q <= blk_d; ce_n_q <= ce_n_d; oe_n_q <= oe_n_d; we_n_q <= we_n_d; pd_n_q <= pd_n_d;
      pd_hv_q <= pd_hv_d; oe_hv_q <= oe_hv_d; vpp_q <= vpp_d; dq_q <= dq_d; rdat_q <= rdat_d;
      dq_oe_q <= dq_oe_d; done_q <= done_d; err_q <= err_d;
    end
  end

  assign o_cmd_ready    = (st_q == flash_host_pkg::ST_IDLE);
  assign o_done         = done_q;
  assign o_err          = err_q;
  assign o_rd_data      = rdat_q;
  assign o_erase_active = ers_q;
  assign o_suspended    = susp_q;
  assign o_flash_addr   = addr_q;
  assign o_flash_dq_out = dq_q;
  assign o_flash_dq_oe  = dq_oe_q;
  assign o_flash_ce_n   = ce_n_q;
  assign o_flash_oe_n   = oe_n_q;
  assign o_flash_we_n   = we_n_q;
  assign o_flash_pd_n   = pd_n_q;
  assign o_flash_pd_hv  = pd_hv_q;
  assign o_flash_oe_hv  = oe_hv_q;
  assign o_flash_vpp_en = vpp_q;

  // ***********************************************
  // checks
  // ***********************************************
  logic [7:0] pd_cnt_q, hv_cnt_q, wehi_cnt_q, last_wr_q;
  logic       latch, ready_seen_q, ce_prev_q;
  // rising chip enable with write enable low, the device's latch edge
  assign latch = ce_n_q && !ce_prev_q && !we_n_q;
  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      pd_cnt_q <= 8'h00; hv_cnt_q <= 8'h00; wehi_cnt_q <= 8'h00; last_wr_q <= 8'h00; ready_seen_q <= 1'b0;
      ce_prev_q <= 1'b1;
    end else begin
      ce_prev_q  <= ce_n_q;
      pd_cnt_q   <= !pd_n_q ? 8'h00 : (pd_cnt_q == 8'hff ? pd_cnt_q : pd_cnt_q + 8'h01);
      hv_cnt_q   <= !oe_hv_q ? 8'h00 : (hv_cnt_q == 8'hff ? hv_cnt_q : hv_cnt_q + 8'h01);
      wehi_cnt_q <= !we_n_q ? 8'h00 : (wehi_cnt_q == 8'hff ? wehi_cnt_q : wehi_cnt_q + 8'h01);
      if (latch) begin
        last_wr_q <= dq_q;
      end
      if (st_q == flash_host_pkg::ST_R_GAP && rdat_q[flash_host_pkg::SR_READY_BIT]) begin
        ready_seen_q <= 1'b1;
      end else if (st_q == flash_host_pkg::ST_PREP) begin
        ready_seen_q <= 1'b0;
      end
    end
  end

  pd_recovery_a: assert property (@(posedge i_ref_clk) disable iff (i_rst)
    $fell(ce_n_q) |-> pd_cnt_q >= 8'(flash_host_pkg::PD_RECOVERY_CYC))
    else $error("chip enable fell too soon after power-down release");
  oe_hv_setup_a: assert property (@(posedge i_ref_clk) disable iff (i_rst)
    $fell(we_n_q) && oe_hv_q |-> hv_cnt_q >= 8'(flash_host_pkg::HV_SETUP_CYC))
    else $error("output enable high voltage setup too short");
  oe_hv_hold_a: assert property (@(posedge i_ref_clk) disable iff (i_rst)
    $fell(oe_hv_q) |-> $past(wehi_cnt_q) >= 8'(flash_host_pkg::HV_HOLD_CYC))
    else $error("output enable high voltage hold too short");
  suspend_erase_a: assert property (@(posedge i_ref_clk) disable iff (i_rst)
    latch && !idx_q && dq_q == flash_host_pkg::CMD_SUSPEND |-> ers_q && !susp_q)
    else $error("suspend written with no running erase");
  poll_toggle_a: assert property (@(posedge i_ref_clk) disable iff (i_rst)
    $rose(oe_n_q) |-> ce_n_q ##1 oe_n_q && ce_n_q)
    else $error("status poll without enable toggle");
  read_other_a: assert property (@(posedge i_ref_clk) disable iff (i_rst)
    $fell(oe_n_q) && susp_q && op_q == flash_host_pkg::OP_READ |->
      flash_host_pkg::block_of(addr_q, BOOT_TOP) != blk_q)
    else $error("read from suspended block");
  vpp_hold_a: assert property (@(posedge i_ref_clk) disable iff (i_rst)
    $fell(vpp_q) || $fell(pd_hv_q) |-> ready_seen_q)
    else $error("supply dropped before ready status");
  boot_unlock_a: assert property (@(posedge i_ref_clk) disable iff (i_rst)
    latch && vpp_q && (op_q == flash_host_pkg::OP_ERASE || op_q == flash_host_pkg::OP_PROGRAM) &&
      flash_host_pkg::block_of(addr_q, BOOT_TOP) == flash_host_pkg::BLK_BOOT |->
      pd_hv_q || oe_hv_q)
    else $error("boot block written while locked");
  erase_pair_a: assert property (@(posedge i_ref_clk) disable iff (i_rst)
    latch && op_q != flash_host_pkg::OP_PROGRAM && dq_q == flash_host_pkg::CMD_CONFIRM |->
      last_wr_q == flash_host_pkg::CMD_ERASE_SETUP || last_wr_q == flash_host_pkg::CMD_READ_STATUS)
    else $error("confirm without setup or status mode");
  no_susp_write_a: assert property (@(posedge i_ref_clk) disable iff (i_rst)
    latch && susp_q && (dq_q == flash_host_pkg::CMD_ERASE_SETUP || dq_q == flash_host_pkg::CMD_PROG_SETUP) |->
      flash_host_pkg::block_of(addr_q, BOOT_TOP) != blk_q)
    else $error("program or erase aimed at suspended block");
endmodule : flash_host_ctrl
`default_nettype wire

/* File: hdl/flash_host_pkg.sv */
// constants and types for the boot-block flash host controller
//
// Summary of operation
// - during a block erase the host pauses it with the suspend code and restarts it with the resume code.
// - after suspend the host polls the status byte bit 7, toggling chip and output enable for every fresh read.
// - while suspended the host writes read-array and reads only blocks other than the suspended one.
// - after raising the power-down pin the host waits 480 ns before chip enable falls.
// - with output-enable unlock the high voltage stands 480 ns before write enable falls and 480 ns after it rises.
// - the host keeps the programming supply and the pin unlock level until ready status is read back.
// - boot-block program and erase use the normal codes and only while an unlock high voltage is applied.
// - a block erase is the setup code then the confirm code, both at an address inside that block.
`default_nettype none
package flash_host_pkg;
  // ***********************************************
  // command codes
  // ***********************************************
  localparam logic [7:0] CMD_ERASE_SETUP   = 8'h20;
  localparam logic [7:0] CMD_CONFIRM       = 8'hd0;
  localparam logic [7:0] CMD_SUSPEND       = 8'hb0;
  localparam logic [7:0] CMD_READ_ARRAY    = 8'hff;
  localparam logic [7:0] CMD_PROG_SETUP    = 8'h40;
  localparam logic [7:0] CMD_READ_STATUS   = 8'h70;
  // ***********************************************
  // status fields
  // ***********************************************
  localparam int         SR_READY_BIT      = 7;
  localparam int         SR_SUSP_BIT       = 6;
  // ***********************************************
  // timing
  // ***********************************************
  localparam int         CLK_PERIOD_NS     = 40;
  localparam int         PD_RECOVERY_NS    = 480;
  localparam int         HV_SETUP_NS       = 480;
  localparam int         HV_HOLD_NS        = 480;
  localparam int         VPP_SETUP_NS      = 100;
  localparam int         PD_RECOVERY_CYC   = (PD_RECOVERY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int         HV_SETUP_CYC      = (HV_SETUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int         HV_HOLD_CYC       = (HV_HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int         VPP_SETUP_CYC     = (VPP_SETUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int         TIMER_W           = 8;
  // ***********************************************
  // block map
  // ***********************************************
  localparam logic [1:0] BLK_BOOT          = 2'h0;
  localparam logic [1:0] BLK_PARAM1        = 2'h1;
  localparam logic [1:0] BLK_PARAM2        = 2'h2;
  localparam logic [1:0] BLK_MAIN          = 2'h3;
  // ***********************************************
  // user operations
  // ***********************************************
  typedef enum logic [2:0] {
    OP_ERASE   = 3'h0,
    OP_PROGRAM = 3'h1,
    OP_SUSPEND = 3'h2,
    OP_RESUME  = 3'h3,
    OP_READ    = 3'h4,
    OP_STATUS  = 3'h5
  } op_t;
  // ***********************************************
  // sequencer states, gray along the usual path
  // ***********************************************
  typedef enum logic [3:0] {
    ST_BOOT  = 4'h0,
    ST_IDLE  = 4'h1,
    ST_PREP  = 4'h3,
    ST_W_WE  = 4'h2,
    ST_W_CE  = 4'h6,
    ST_W_REL = 4'h7,
    ST_W_END = 4'h5,
    ST_HOLD  = 4'h4,
    ST_R_EN  = 4'hc,
    ST_R_SMP = 4'hd,
    ST_R_GAP = 4'hf,
    ST_FIN   = 4'he
  } state_t;

  // block index of a 17-bit address, boot block at top or bottom
  function automatic logic [1:0] block_of(input logic [16:0] a, input logic boot_top);
    logic [16:0] m;
    m = boot_top ? ~a : a;
    if (m[16:13] == 4'h0) begin
      block_of = BLK_BOOT;
    end else if (m[16:12] == 5'h02) begin
      block_of = BLK_PARAM1;
    end else if (m[16:12] == 5'h03) begin
      block_of = BLK_PARAM2;
    end else begin
      block_of = BLK_MAIN;
    end
  endfunction : block_of
endpackage : flash_host_pkg
`default_nettype wire

/* File: hdl/cycle_timer.sv */
// down-counting delay timer with load and expiry flag
`default_nettype none
module cycle_timer #(
  parameter int W = 8
) (
  // clock and reset
  input  wire logic         i_ref_clk,
  input  wire logic         i_rst,
  // control
  input  wire logic         i_load,
  input  wire logic [W-1:0] i_count,
  // status
  output logic              o_done
);
  logic [W-1:0] cnt_q;
  logic [W-1:0] cnt_d;

  always_comb begin
    cnt_d = cnt_q;
    if (i_load) begin
      cnt_d = i_count;
    end else if (cnt_q != '0) begin
      cnt_d = cnt_q - 1'b1;
    end
  end

  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      cnt_q <= '0;
    end else begin
      cnt_q <= cnt_d;
    end
  end

  assign o_done = (cnt_q == '0) && !i_load;
endmodule : cycle_timer
`default_nettype wire

/* File: verif/flash_dev_model.sv */
// behavioural boot-block flash device facing the host controller
`default_nettype none
module flash_dev_model #(
  parameter int ERASE_CYC = 300,
  parameter int PROG_CYC  = 20
) (
  // clock for busy timing and for registering the read data onto o_dq
  input  wire logic        i_ref_clk,
  // device pins
  input  wire logic [16:0] i_addr,
  input  wire logic [7:0]  i_dq,
  input  wire logic        i_ce_n,
  input  wire logic        i_oe_n,
  input  wire logic        i_we_n,
  input  wire logic        i_pd_n,
  input  wire logic        i_hv,
  output logic [7:0]       o_dq
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0] mem [int];
  logic       stat_mode;
  logic       susp;
  logic       lock_err;
  logic [7:0] pend;
  int         busy;
  initial o_dq = 8'h5a;
  always @(posedge i_ce_n or negedge i_pd_n) begin
    if (!i_pd_n) begin
      stat_mode = 1'b0;
      pend = 8'h00;
      busy = 0;
      susp = 1'b0;
      lock_err = 1'b0;
    end else if (!i_we_n) begin
      if (pend != 8'h00 && !i_hv && i_addr[16:13] == 4'h0) lock_err = 1'b1;
      else if (pend == 8'h20 && i_dq == 8'hd0) busy = ERASE_CYC;
      else if (pend == 8'h40) begin
        mem[i_addr] = i_dq;
        busy = PROG_CYC;
      end else if (i_dq == 8'hb0 && busy > 0) susp = 1'b1;
      else if (i_dq == 8'hd0 && susp) susp = 1'b0;
      stat_mode = pend != 8'h00 || i_dq != 8'hff;
      pend = (pend == 8'h00 && (i_dq == 8'h20 || i_dq == 8'h40)) ? i_dq : 8'h00;
    end
  end
  // erase time stands still while suspended
  always @(posedge i_ref_clk) if (busy > 0 && !susp) busy <= busy - 1;
  // released bus shows a changing pattern
  always @(posedge i_ref_clk) begin
    if (!i_ce_n && !i_oe_n) o_dq <= stat_mode ? {busy == 0 || susp, susp, 1'b0, lock_err, 4'h0}
                                              : (mem.exists(i_addr) ? mem[i_addr] : 8'hff);
    else o_dq <= ~o_dq;
  end
endmodule : flash_dev_model
`default_nettype wire

/* File: verif/flash_erase_suspend_and_write_control_bench.sv */
// self-checking bench for the flash host controller with a device model
`default_nettype none
module flash_erase_suspend_and_write_control_bench;
  timeunit 1ns;
  timeprecision 1ns;
  logic        clk, rst, vld, via_oe, f;
  logic [2:0]  op;
  logic [16:0] addr, fa, pa;
  logic [7:0]  din, dq_o, dq_i, rd, val, s;
  logic        rdy, done, err, act, susp, dq_oe, ce_n, oe_n, we_n, pd_n, pd_hv, oe_hv, vpp;
  int          err_total, total_checks, pd_cnt;
  flash_host_ctrl i_flash_host_ctrl (.i_ref_clk(clk), .i_rst(rst), .i_cmd_valid(vld), .i_cmd_op(op),
    .i_cmd_addr(addr), .i_cmd_data(din), .i_boot_via_oe(via_oe), .o_cmd_ready(rdy), .o_done(done),
    .o_err(err), .o_rd_data(rd), .o_erase_active(act), .o_suspended(susp), .o_flash_addr(fa),
    .o_flash_dq_out(dq_o), .o_flash_dq_oe(dq_oe), .i_flash_dq_in(dq_i), .o_flash_ce_n(ce_n),
    .o_flash_oe_n(oe_n), .o_flash_we_n(we_n), .o_flash_pd_n(pd_n), .o_flash_pd_hv(pd_hv),
    .o_flash_oe_hv(oe_hv), .o_flash_vpp_en(vpp));
  flash_dev_model i_flash_dev_model (.i_ref_clk(clk), .i_addr(fa), .i_dq(dq_oe ? dq_o : dq_i), .i_ce_n(ce_n),
    .i_oe_n(oe_n), .i_we_n(we_n), .i_pd_n(pd_n), .i_hv(pd_hv | oe_hv), .o_dq(dq_i));
  task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
    total_checks++;
    if (seen !== exp) begin
      err_total++;
      $display("BAD %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk
  task automatic run(input logic [2:0] o, input logic [16:0] a, input logic [7:0] d, output logic fl);
    @(posedge clk);
    repeat (100) if (rdy !== 1'b1) @(posedge clk);
    vld <= 1'b1;
    op <= o;
    addr <= a;
    din <= d;
    @(posedge clk);
    vld <= 1'b0;
    @(posedge clk);
    repeat (3000) if (done !== 1'b1 && err !== 1'b1) @(posedge clk);
    fl = err;
    @(posedge clk);
  endtask : run
  task automatic poll(input logic [16:0] a, output logic [7:0] st);
    logic e;
    st = 8'h00;
    repeat (100) if (st[7] !== 1'b1) begin
      run(3'h5, a, 8'h00, e);
      st = rd;
    end
  endtask : poll
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : give_verdict
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  // chip enable must wait out recovery after power-down release
  always @(posedge clk) begin
    pd_cnt <= pd_n ? pd_cnt + 1 : 0;
    if (ce_n === 1'b0 && pd_cnt < 12) chk("recovery", 8'(pd_cnt), 8'd12);
  end
  initial begin
    repeat (40000) @(posedge clk);
    err_total++;
    give_verdict();
  end
  initial begin
    rst = 1'b1;
    vld = 1'b0;
    op = 3'h0;
    addr = 17'h00000;
    din = 8'h00;
    via_oe = 1'b0;
    pd_cnt = 0;
    void'($urandom(77735));
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    for (int i = 0; i < 3; i++) begin
      pa = {5'h02, 12'($urandom)};
      val = (i == 0) ? 8'h00 : 8'($urandom);
      run(3'h1, pa, val, f);
      chk("prog_err", f, 1'b0);
      poll(pa, s);
      chk("prog_stat", s[7:4], 4'h8);
      run(3'h4, pa, 8'h00, f);
      chk("prog_read", rd, val);
    end
    $display("test program done");
    run(3'h0, {4'h8, 13'($urandom)}, 8'h00, f);
    chk("erase_err", {f, act}, 2'b01);
    run(3'h2, 17'h10000, 8'h00, f);
    chk("susp_stat", {f, rd[7:6], susp}, 4'b0111);
    run(3'h4, pa, 8'h00, f);
    chk("susp_read_err", f, 1'b0);
    chk("susp_read", rd, val);
    run(3'h4, 17'h1f000, 8'h00, f);
    chk("read_susp_blk", f, 1'b1);
    run(3'h0, 17'h04000, 8'h00, f);
    chk("erase_twice", f, 1'b1);
    run(3'h3, 17'h10000, 8'h00, f);
    chk("resume", {f, susp}, 2'b00);
    run(3'h5, 17'h10000, 8'h00, f);
    chk("busy_after_resume", rd[7:6], 2'b00);
    poll(17'h10000, s);
    chk("erase_end", {s[7:6], act}, 3'b100);
    $display("test suspend done");
    for (int k = 0; k < 4; k++) begin
      run(k < 2 ? 3'(k + 2) : 3'(k + 4), pa, 8'h00, f);
      chk("refuse", f, 1'b1);
    end
    $display("test refusals done");
    for (int v = 0; v < 2; v++) begin
      via_oe <= v[0];
      run(3'h0, 17'h00100, 8'h00, f);
      poll(17'h00100, s);
      chk("boot_erase", {f, s[4], act}, 3'b000);
    end
    $display("test boot done");
    give_verdict();
  end
endmodule : flash_erase_suspend_and_write_control_bench
`default_nettype wire
